// ===== core/mbd_decoder_top.sv
// decode and cycle timing for move, branch and bit instructions
// Notes on behaviour
// - 0x75 immediate to direct, 3 bytes 3 cycles
// - 0xF6-F7 accumulator to indirect, 1 byte 3
// - 0xA6-A7 direct to indirect, 2 bytes 5
// - 0x76-77 immediate to indirect, 2 bytes 3
// - 0x90 loads data pointer, 3 bytes 3
// - 0x93/0x83 code byte fetch, 1 byte 3
// - external reads 0xE2-E3/0xE0, 3 to 10 cycles
// - external writes 0xF2-F3/0xF0, 4 to 11 cycles
// - push 0xC0 4 cycles, pop 0xD0 3
// - accumulator swaps 0xC8-CF, 0xC5, 0xC6-C7
// - 0xD6-D7 swaps low nibbles only, 3 cycles
// - calls take 6; absolute xxx10001b, long 0x12
// - 0x80 short relative jump, 2 bytes 3
// - 0x73 jump accumulator plus pointer, 2 cycles
// - 0x60/0x70/0x40/0x50 conditional jumps, 2 bytes 3
// - 0x20/0x30 bit conditional jumps, 3 bytes 4
// - 0x10 jumps if bit set, clears it
// - compare jump unequal 0xB4-BF, 3 bytes 4
// - decrement jump 0xD8-DF 2/3, 0xD5 3/4
// - bit clear/set/invert, carry-only forms one cycle
// - carry and/or with bit or complement
// - 0xA2 bit to carry, 0x92 carry to bit
`timescale 1ns/1ps
module mbd_decoder_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // opcode fetch
    input wire logic op_valid,
    input wire logic [7:0] op_byte,
    output logic op_ready,
    // datapath operands, read in the last execution cycle
    input wire logic [7:0] acc_val,
    input wire logic carry_val,
    input wire logic bit_val,
    input wire logic [7:0] opnd_a,
    input wire logic [7:0] opnd_b,
    // external data wait states, read at accept
    input wire logic [2:0] ext_wait,
    // decoded instruction
    output logic dec_valid,
    output logic [5:0] dec_class,
    output logic [1:0] dec_len,
    output logic [3:0] dec_cycles,
    output logic [2:0] bank_sel,
    output logic ptr_sel,
    output logic [2:0] call_addr_hi,
    output logic unsupported,
    // memory side requests
    output logic ext_rd,
    output logic ext_wr,
    output logic use_data_pointer,
    output logic code_fetch,
    output logic stack_push,
    output logic stack_pop,
    output logic nibble_only,
    // completion
    output logic busy,
    output logic exec_done,
    output logic jump_taken,
    output logic bit_clear_req,
    output logic compare_below
);
    // ----------------------------
    // local names for shared constants
    // ----------------------------
    localparam logic [1:0] L1 = mbd_pkg::LEN_1;
    localparam logic [1:0] L2 = mbd_pkg::LEN_2;
    localparam logic [1:0] L3 = mbd_pkg::LEN_3;
    localparam logic [3:0] C1 = mbd_pkg::CYC_1;
    localparam logic [3:0] C2 = mbd_pkg::CYC_2;
    localparam logic [3:0] C3 = mbd_pkg::CYC_3;
    localparam logic [3:0] C4 = mbd_pkg::CYC_4;
    localparam logic [3:0] C5 = mbd_pkg::CYC_5;
    localparam logic [3:0] C6 = mbd_pkg::CYC_6;
    localparam mbd_pkg::mbd_cond_t KN = mbd_pkg::CD_NONE;
    localparam mbd_pkg::mbd_cond_t KA = mbd_pkg::CD_ALWAYS;

    // ----------------------------
    // types
    // ----------------------------
    typedef enum logic [5:0] {
        OC_NONE = 6'b000000,
        OC_MV_DIR_IMM = 6'b000001,
        OC_MV_IND_ACC = 6'b000010,
        OC_MV_IND_DIR = 6'b000011,
        OC_MV_IND_IMM = 6'b000100,
        OC_DP_LOAD = 6'b000101,
        OC_CODE_DP = 6'b000110,
        OC_CODE_PC = 6'b000111,
        OC_XRD_REG = 6'b001000,
        OC_XRD_DP = 6'b001001,
        OC_XWR_REG = 6'b001010,
        OC_XWR_DP = 6'b001011,
        OC_STK_PUSH = 6'b001100,
        OC_STK_POP = 6'b001101,
        OC_SWP_REG = 6'b001110,
        OC_SWP_DIR = 6'b001111,
        OC_SWP_IND = 6'b010000,
        OC_SWP_NIB = 6'b010001,
        OC_CALL_ABS = 6'b010010,
        OC_CALL_LONG = 6'b010011,
        OC_BR_SHORT = 6'b010100,
        OC_BR_IND = 6'b010101,
        OC_BR_AZ = 6'b010110,
        OC_BR_ANZ = 6'b010111,
        OC_BR_CS = 6'b011000,
        OC_BR_CC = 6'b011001,
        OC_BR_BS = 6'b011010,
        OC_BR_BC = 6'b011011,
        OC_BR_BSC = 6'b011100,
        OC_CMP_DIR = 6'b011101,
        OC_CMP_IMM = 6'b011110,
        OC_CMP_REG = 6'b011111,
        OC_CMP_IND = 6'b100000,
        OC_DEC_REG = 6'b100001,
        OC_DEC_DIR = 6'b100010,
        OC_BIT_CLR = 6'b100011,
        OC_BIT_SET = 6'b100100,
        OC_BIT_INV = 6'b100101,
        OC_CY_CLR = 6'b100110,
        OC_CY_SET = 6'b100111,
        OC_CY_INV = 6'b101000,
        OC_CY_AND = 6'b101001,
        OC_CY_ANDN = 6'b101010,
        OC_CY_OR = 6'b101011,
        OC_CY_ORN = 6'b101100,
        OC_CY_LOAD = 6'b101101,
        OC_BIT_STORE = 6'b101110
    } mbd_opc_t;

    typedef struct packed {
        mbd_opc_t cls;
        logic [1:0] len;
        logic [3:0] cyc;
        mbd_pkg::mbd_cond_t cond;
    } mbd_dec_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_DONE = 2'b10
    } mbd_state_t;

    // ----------------------------
    // opcode table
    // ----------------------------
    function automatic mbd_dec_t decode(input logic [7:0] op);
        mbd_dec_t d;
        d = '{OC_NONE, L1, C1, KN};
        casez (op)
            8'h75: d = '{OC_MV_DIR_IMM, L3, C3, KN};
            8'b1111011?: d = '{OC_MV_IND_ACC, L1, C3, KN};
            8'b1010011?: d = '{OC_MV_IND_DIR, L2, C5, KN};
            8'b0111011?: d = '{OC_MV_IND_IMM, L2, C3, KN};
            8'h90: d = '{OC_DP_LOAD, L3, C3, KN};
            8'h93: d = '{OC_CODE_DP, L1, C3, KN};
            8'h83: d = '{OC_CODE_PC, L1, C3, KN};
            8'b1110001?: d = '{OC_XRD_REG, L1, mbd_pkg::EXT_RD_MIN, KN};
            8'he0: d = '{OC_XRD_DP, L1, mbd_pkg::EXT_RD_MIN, KN};
            8'b1111001?: d = '{OC_XWR_REG, L1, mbd_pkg::EXT_WR_MIN, KN};
            8'hf0: d = '{OC_XWR_DP, L1, mbd_pkg::EXT_WR_MIN, KN};
            8'hc0: d = '{OC_STK_PUSH, L2, C4, KN};
            8'hd0: d = '{OC_STK_POP, L2, C3, KN};
            8'b11001???: d = '{OC_SWP_REG, L1, C2, KN};
            8'hc5: d = '{OC_SWP_DIR, L2, C3, KN};
            8'b1100011?: d = '{OC_SWP_IND, L1, C3, KN};
            8'b1101011?: d = '{OC_SWP_NIB, L1, C3, KN};
            8'b???10001: d = '{OC_CALL_ABS, L2, C6, KA};
            8'h12: d = '{OC_CALL_LONG, L3, C6, KA};
            8'h80: d = '{OC_BR_SHORT, L2, C3, KA};
            8'h73: d = '{OC_BR_IND, L1, C2, KA};
            8'h60: d = '{OC_BR_AZ, L2, C3, mbd_pkg::CD_ACC_Z};
            8'h70: d = '{OC_BR_ANZ, L2, C3, mbd_pkg::CD_ACC_NZ};
            8'h40: d = '{OC_BR_CS, L2, C3, mbd_pkg::CD_CY_SET};
            8'h50: d = '{OC_BR_CC, L2, C3, mbd_pkg::CD_CY_CLR};
            8'h20: d = '{OC_BR_BS, L3, C4, mbd_pkg::CD_BIT_SET};
            8'h30: d = '{OC_BR_BC, L3, C4, mbd_pkg::CD_BIT_CLR};
            8'h10: d = '{OC_BR_BSC, L3, C4, mbd_pkg::CD_BIT_SET};
            8'hb5: d = '{OC_CMP_DIR, L3, C4, mbd_pkg::CD_UNEQUAL};
            8'hb4: d = '{OC_CMP_IMM, L3, C4, mbd_pkg::CD_UNEQUAL};
            8'b10111???: d = '{OC_CMP_REG, L3, C4, mbd_pkg::CD_UNEQUAL};
            8'b1011011?: d = '{OC_CMP_IND, L3, C4, mbd_pkg::CD_UNEQUAL};
            8'b11011???: d = '{OC_DEC_REG, L2, C3, mbd_pkg::CD_DEC_NZ};
            8'hd5: d = '{OC_DEC_DIR, L3, C4, mbd_pkg::CD_DEC_NZ};
            8'hc2: d = '{OC_BIT_CLR, L2, C3, KN};
            8'hd2: d = '{OC_BIT_SET, L2, C3, KN};
            8'hb2: d = '{OC_BIT_INV, L2, C3, KN};
            8'hc3: d = '{OC_CY_CLR, L1, C1, KN};
            8'hd3: d = '{OC_CY_SET, L1, C1, KN};
            8'hb3: d = '{OC_CY_INV, L1, C1, KN};
            8'h82: d = '{OC_CY_AND, L2, C2, KN};
            8'hb0: d = '{OC_CY_ANDN, L2, C2, KN};
            8'h72: d = '{OC_CY_OR, L2, C2, KN};
            8'ha0: d = '{OC_CY_ORN, L2, C2, KN};
            8'ha2: d = '{OC_CY_LOAD, L2, C2, KN};
            8'h92: d = '{OC_BIT_STORE, L2, C3, KN};
            default: d = '{OC_NONE, L1, C1, KN};
        endcase
        return d;
    endfunction : decode

    // ----------------------------
    // decode of the offered opcode
    // ----------------------------
    mbd_dec_t dec;
    logic [3:0] cyc_nxt;
    logic [3:0] ext_rd_cyc;
    logic [3:0] ext_wr_cyc;
    logic accept;

    assign dec = decode(op_byte);
    assign ext_rd_cyc = mbd_pkg::EXT_RD_MIN + {1'b0, ext_wait};
    assign ext_wr_cyc = mbd_pkg::EXT_WR_MIN + {1'b0, ext_wait};

    // wait states stretch external access up to its ceiling
    always_comb begin
        cyc_nxt = dec.cyc;
        if (dec.cls inside {OC_XRD_REG, OC_XRD_DP}) begin
            cyc_nxt = (ext_rd_cyc > mbd_pkg::EXT_RD_MAX) ? mbd_pkg::EXT_RD_MAX : ext_rd_cyc;
        end else if (dec.cls inside {OC_XWR_REG, OC_XWR_DP}) begin
            cyc_nxt = (ext_wr_cyc > mbd_pkg::EXT_WR_MAX) ? mbd_pkg::EXT_WR_MAX : ext_wr_cyc;
        end
    end

    // ----------------------------
    // sequencing
    // ----------------------------
    mbd_state_t state_r;
    mbd_state_t state_nxt;
    logic op_ready_r;
    mbd_exec_if #(.CYC_W(4)) ex ();

    assign accept = op_valid && op_ready_r && clk_en;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: if (accept) state_nxt = ST_EXEC;
            ST_EXEC: if (ex.last) state_nxt = ST_DONE;
            ST_DONE: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
            op_ready_r <= 1'b0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            op_ready_r <= state_nxt == ST_IDLE;
        end
    end

    assign ex.start = accept;
    assign ex.load = cyc_nxt;
    assign ex.acc = acc_val;
    assign ex.carry = carry_val;
    assign ex.bit_val = bit_val;
    assign ex.opnd_a = opnd_a;
    assign ex.opnd_b = opnd_b;

    mbd_cycle_timer #(.CYC_W(4)) u_timer (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .ex(ex.timer)
    );

    mbd_branch_judge u_judge (
        .ex(ex.judge)
    );

    // ----------------------------
    // decoded fields, held for the whole instruction
    // ----------------------------
    mbd_opc_t cls_r;
    logic [1:0] len_r;
    logic [3:0] cyc_r;
    logic [2:0] bank_r;
    logic ptr_r;
    logic [2:0] ahi_r;
    logic dec_valid_r;
    logic unsup_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cls_r <= OC_NONE;
            len_r <= L1;
            cyc_r <= C1;
            bank_r <= 3'h0;
            ptr_r <= 1'b0;
            ahi_r <= 3'h0;
            ex.cond <= KN;
        end else if (accept) begin
            cls_r <= dec.cls;
            len_r <= dec.len;
            cyc_r <= cyc_nxt;
            bank_r <= op_byte[mbd_pkg::BANK_MSB:mbd_pkg::BANK_LSB];
            ptr_r <= op_byte[mbd_pkg::PTR_BIT];
            ahi_r <= op_byte[mbd_pkg::AHI_MSB:mbd_pkg::AHI_LSB];
            ex.cond <= dec.cond;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            dec_valid_r <= 1'b0;
            unsup_r <= 1'b0;
        end else if (clk_en) begin
            dec_valid_r <= state_nxt != ST_IDLE;
            // registered so the flag leaves a flip-flop like every other output
            unsup_r <= state_nxt != ST_IDLE && (accept ? dec.cls == OC_NONE : cls_r == OC_NONE);
        end
    end

    // ----------------------------
    // memory side requests, high while executing
    // ----------------------------
    logic ext_rd_r;
    logic ext_wr_r;
    logic dp_r;
    logic code_r;
    logic push_r;
    logic pop_r;
    logic nib_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ext_rd_r <= 1'b0;
            ext_wr_r <= 1'b0;
            dp_r <= 1'b0;
            code_r <= 1'b0;
            push_r <= 1'b0;
            pop_r <= 1'b0;
            nib_r <= 1'b0;
        end else if (accept) begin
            ext_rd_r <= dec.cls inside {OC_XRD_REG, OC_XRD_DP};
            ext_wr_r <= dec.cls inside {OC_XWR_REG, OC_XWR_DP};
            dp_r <= dec.cls inside {OC_XRD_DP, OC_XWR_DP, OC_CODE_DP, OC_BR_IND, OC_DP_LOAD};
            code_r <= dec.cls inside {OC_CODE_DP, OC_CODE_PC};
            push_r <= dec.cls inside {OC_STK_PUSH, OC_CALL_ABS, OC_CALL_LONG};
            pop_r <= dec.cls == OC_STK_POP;
            nib_r <= dec.cls == OC_SWP_NIB;
        end else if (clk_en && ex.last) begin
            ext_rd_r <= 1'b0;
            ext_wr_r <= 1'b0;
            dp_r <= 1'b0;
            code_r <= 1'b0;
            push_r <= 1'b0;
            pop_r <= 1'b0;
            nib_r <= 1'b0;
        end
    end

    // ----------------------------
    // completion and branch outcome
    // ----------------------------
    logic done_r;
    logic taken_r;
    logic bclr_r;
    logic below_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            done_r <= 1'b0;
        end else if (clk_en) begin
            done_r <= ex.last;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            taken_r <= 1'b0;
            bclr_r <= 1'b0;
            below_r <= 1'b0;
        end else if (accept) begin
            taken_r <= 1'b0;
            bclr_r <= 1'b0;
            below_r <= 1'b0;
        end else if (clk_en && ex.last) begin
            taken_r <= ex.taken;
            bclr_r <= cls_r == OC_BR_BSC && ex.taken;
            below_r <= cls_r inside {OC_CMP_DIR, OC_CMP_IMM, OC_CMP_REG, OC_CMP_IND} && ex.below;
        end
    end

    // ----------------------------
    // outputs
    // ----------------------------
    assign op_ready = op_ready_r;
    assign dec_valid = dec_valid_r;
    assign dec_class = cls_r;
    assign dec_len = len_r;
    assign dec_cycles = cyc_r;
    assign bank_sel = bank_r;
    assign ptr_sel = ptr_r;
    assign call_addr_hi = ahi_r;
    assign unsupported = unsup_r;
    assign ext_rd = ext_rd_r;
    assign ext_wr = ext_wr_r;
    assign use_data_pointer = dp_r;
    assign code_fetch = code_r;
    assign stack_push = push_r;
    assign stack_pop = pop_r;
    assign nibble_only = nib_r;
    assign busy = ex.busy;
    assign exec_done = done_r;
    assign jump_taken = taken_r;
    assign bit_clear_req = bclr_r;
    assign compare_below = below_r;
endmodule : mbd_decoder_top

// ===== core/mbd_pkg.sv
// shared constants and types for the move, branch and bit decoder
package mbd_pkg;
    // ----------------------------
    // instruction lengths in bytes
    // ----------------------------
    localparam logic [1:0] LEN_1 = 2'h1;
    localparam logic [1:0] LEN_2 = 2'h2;
    localparam logic [1:0] LEN_3 = 2'h3;
    // ----------------------------
    // execution cycle counts
    // ----------------------------
    localparam logic [3:0] CYC_1 = 4'h1;
    localparam logic [3:0] CYC_2 = 4'h2;
    localparam logic [3:0] CYC_3 = 4'h3;
    localparam logic [3:0] CYC_4 = 4'h4;
    localparam logic [3:0] CYC_5 = 4'h5;
    localparam logic [3:0] CYC_6 = 4'h6;
    localparam logic [3:0] EXT_RD_MIN = 4'h3;
    localparam logic [3:0] EXT_RD_MAX = 4'ha;
    localparam logic [3:0] EXT_WR_MIN = 4'h4;
    localparam logic [3:0] EXT_WR_MAX = 4'hb;
    // ----------------------------
    // opcode fields and compare constants
    // ----------------------------
    localparam int BANK_LSB = 0;
    localparam int BANK_MSB = 2;
    localparam int PTR_BIT = 0;
    localparam int AHI_LSB = 5;
    localparam int AHI_MSB = 7;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] ONE_BYTE = 8'h01;
    // ----------------------------
    // branch conditions
    // ----------------------------
    typedef enum logic [3:0] {
        CD_NONE = 4'b0000,
        CD_ALWAYS = 4'b0001,
        CD_ACC_Z = 4'b0010,
        CD_ACC_NZ = 4'b0011,
        CD_CY_SET = 4'b0100,
        CD_CY_CLR = 4'b0101,
        CD_BIT_SET = 4'b0110,
        CD_BIT_CLR = 4'b0111,
        CD_UNEQUAL = 4'b1000,
        CD_DEC_NZ = 4'b1001
    } mbd_cond_t;
endpackage : mbd_pkg

// ===== core/mbd_exec_if.sv
// timer and branch condition signals shared inside the decoder
`timescale 1ns/1ps
interface mbd_exec_if #(parameter int CYC_W = 4);
    logic start;
    logic [CYC_W-1:0] load;
    logic busy;
    logic last;
    mbd_pkg::mbd_cond_t cond;
    logic [7:0] acc;
    logic carry;
    logic bit_val;
    logic [7:0] opnd_a;
    logic [7:0] opnd_b;
    logic taken;
    logic below;
    modport ctrl (output start, load, cond, acc, carry, bit_val, opnd_a, opnd_b,
                  input busy, last, taken, below);
    modport timer (input start, load, output busy, last);
    modport judge (input cond, acc, carry, bit_val, opnd_a, opnd_b, output taken, below);
endinterface : mbd_exec_if

// ===== core/mbd_cycle_timer.sv
// execution cycle counter
`timescale 1ns/1ps
module mbd_cycle_timer #(parameter int CYC_W = 4) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // control
    mbd_exec_if.timer ex
);
    logic [CYC_W-1:0] cnt_r;
    logic busy_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            busy_r <= 1'b0;
        end else if (clk_en) begin
            if (ex.start) begin
                busy_r <= 1'b1;
            end else if (busy_r && cnt_r == '0) begin
                busy_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cnt_r <= '0;
        end else if (clk_en) begin
            if (ex.start) begin
                cnt_r <= ex.load - CYC_W'(1);
            end else if (busy_r && cnt_r != '0) begin
                cnt_r <= cnt_r - CYC_W'(1);
            end
        end
    end

    assign ex.busy = busy_r;
    assign ex.last = busy_r && cnt_r == '0;
endmodule : mbd_cycle_timer

// ===== core/mbd_branch_judge.sv
// branch condition evaluation
`timescale 1ns/1ps
module mbd_branch_judge (
    // operands and condition
    mbd_exec_if.judge ex
);
    always_comb begin
        ex.taken = 1'b0;
        unique case (ex.cond)
            mbd_pkg::CD_NONE: ex.taken = 1'b0;
            mbd_pkg::CD_ALWAYS: ex.taken = 1'b1;
            mbd_pkg::CD_ACC_Z: ex.taken = ex.acc == mbd_pkg::ZERO_BYTE;
            mbd_pkg::CD_ACC_NZ: ex.taken = ex.acc != mbd_pkg::ZERO_BYTE;
            mbd_pkg::CD_CY_SET: ex.taken = ex.carry;
            mbd_pkg::CD_CY_CLR: ex.taken = !ex.carry;
            mbd_pkg::CD_BIT_SET: ex.taken = ex.bit_val;
            mbd_pkg::CD_BIT_CLR: ex.taken = !ex.bit_val;
            mbd_pkg::CD_UNEQUAL: ex.taken = ex.opnd_a != ex.opnd_b;
            // value before the decrement; taken unless it reaches zero
            mbd_pkg::CD_DEC_NZ: ex.taken = ex.opnd_a != mbd_pkg::ONE_BYTE;
            default: ex.taken = 1'b0;
        endcase
    end

    // carry result of a compare
    assign ex.below = ex.opnd_a < ex.opnd_b;
endmodule : mbd_branch_judge

// ===== sim/mbd_decoder_properties.sv
// assertions on the decoder top ports
`timescale 1ns/1ps
module mbd_decoder_properties (
    // clock and fetch
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic op_valid,
    input wire logic op_ready,
    // decode and execution
    input wire logic dec_valid,
    input wire logic [5:0] dec_class,
    input wire logic [1:0] dec_len,
    input wire logic [3:0] dec_cycles,
    input wire logic busy,
    input wire logic exec_done
);
    logic [3:0] cnt_r;
    wire logic take = op_valid && op_ready && clk_en;
    // ----
    // enabled busy cycles since accept
    // ----
    always_ff @(posedge sys_clk) begin
        if (!rst_b || take) begin
            cnt_r <= 4'h0;
        end else if (clk_en && busy) begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    a_take_starts: assert property (take |=> busy && dec_valid && !op_ready)
        else $error("no execution after accept");
    a_count_match: assert property (exec_done |-> cnt_r == dec_cycles)
        else $error("busy length differs");
    a_done_ready: assert property (exec_done && clk_en |=> !exec_done && op_ready)
        else $error("done or ready wrong");
    a_imm_direct: assert property (dec_valid && dec_class == 6'h01 |-> dec_len == 2'h3 && dec_cycles == 4'h3)
        else $error("immediate store timing");
    a_copy_ind: assert property (dec_valid && dec_class == 6'h03 |-> dec_len == 2'h2 && dec_cycles == 4'h5)
        else $error("indirect copy timing");
    a_push_four: assert property (dec_valid && dec_class == 6'h0c |-> dec_cycles == 4'h4)
        else $error("push timing");
    a_call_six: assert property (dec_valid && dec_class inside {6'h12, 6'h13} |-> dec_cycles == 4'h6)
        else $error("call timing");
    a_carry_only: assert property (dec_valid && dec_class inside {[6'h26:6'h28]} |-> dec_cycles == 4'h1)
        else $error("carry form timing");
endmodule : mbd_decoder_properties

// ===== sim/mbd_mem_model.sv
// memory side model: operand lines valid only during execution
`timescale 1ns/1ps
module mbd_mem_model (
    // control and held values
    input wire logic busy,
    input wire logic [25:0] held,
    // operand lines
    output logic [7:0] acc_val,
    output logic [7:0] opnd_a,
    output logic [7:0] opnd_b,
    output logic carry_val,
    output logic bit_val
);
    // released lines show the inverse so stale data cannot pass
    assign {acc_val, opnd_a, opnd_b, carry_val, bit_val} = busy ? held : ~held;
endmodule : mbd_mem_model

// ===== sim/mbd_decoder_top_bench.sv
// self-checking bench for the move, branch and bit decoder
`timescale 1ns/1ps
module mbd_decoder_top_bench;
    logic sys_clk, rst_b, clk_en, op_valid, cy, bt, carry_val, bit_val, op_ready, dec_valid, ptr_sel;
    logic unsupported, busy, exec_done, jump_taken, bit_clear_req, compare_below;
    logic ext_rd, ext_wr, use_data_pointer, code_fetch, stack_push, stack_pop, nibble_only;
    logic [7:0] op_byte, ac, oa, ob, acc_val, opnd_a, opnd_b;
    logic [2:0] ext_wait, bank_sel, call_addr_hi;
    logic [5:0] dec_class;
    logic [1:0] dec_len;
    logic [3:0] dec_cycles;
    int n_errors, checks;
    wire logic [6:0] reqs = {ext_rd, ext_wr, use_data_pointer, code_fetch, stack_push, stack_pop, nibble_only};
    // opcode, mask, class with length, cycles
    localparam logic [27:0] TBL [46] = '{
        28'h75ff073, 28'hf6fe093, 28'ha6fe0e5, 28'h76fe123, 28'h90ff173, 28'h93ff193, 28'h83ff1d3, 28'he2fe213,
        28'he0ff253, 28'hf2fe294, 28'hf0ff2d4, 28'hc0ff324, 28'hd0ff363, 28'hc8f8392, 28'hc5ff3e3, 28'hc6fe413,
        28'hd6fe453, 28'h111f4a6, 28'h12ff4f6, 28'h80ff523, 28'h73ff552, 28'h60ff5a3, 28'h70ff5e3, 28'h40ff623,
        28'h50ff663, 28'h20ff6b4, 28'h30ff6f4, 28'h10ff734, 28'hb5ff774, 28'hb4ff7b4, 28'hb8f87f4, 28'hb6fe834,
        28'hd8f8863, 28'hd5ff8b4, 28'hc2ff8e3, 28'hd2ff923, 28'hb2ff963, 28'hc3ff991, 28'hd3ff9d1, 28'hb3ffa11,
        28'h82ffa62, 28'hb0ffaa2, 28'h72ffae2, 28'ha0ffb22, 28'ha2ffb62, 28'h92ffba3};
    mbd_decoder_top i_mbd_decoder_top (.sys_clk, .rst_b, .clk_en, .op_valid, .op_byte, .op_ready, .acc_val,
        .carry_val, .bit_val, .opnd_a, .opnd_b, .ext_wait, .dec_valid, .dec_class, .dec_len, .dec_cycles,
        .bank_sel, .ptr_sel, .call_addr_hi, .unsupported, .ext_rd, .ext_wr, .use_data_pointer, .code_fetch,
        .stack_push, .stack_pop, .nibble_only, .busy, .exec_done, .jump_taken, .bit_clear_req, .compare_below);
    mbd_mem_model i_mbd_mem_model (.busy, .held({ac, oa, ob, cy, bt}), .acc_val, .opnd_a, .opnd_b,
        .carry_val, .bit_val);
    // ----
    // reference model and checks
    // ----
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test
    function automatic logic [11:0] model(input logic [7:0] op, input logic [2:0] w);
        logic [11:0] r;
        r = 12'h011;
        for (int i = 0; i < 46; i++) begin
            if ((op & TBL[i][19:12]) == TBL[i][27:20]) r = TBL[i][11:0];
        end
        // wait states stretch external access up to its ceiling
        if (r[11:8] == 4'h2) r[3:0] = r[3:0] + {1'b0, w};
        return r;
    endfunction : model
    function automatic logic [6:0] req_of(input logic [5:0] c);
        return {c inside {6'h08, 6'h09}, c inside {6'h0a, 6'h0b}, c inside {6'h05, 6'h06, 6'h09, 6'h0b, 6'h15},
                c inside {6'h06, 6'h07}, c inside {6'h0c, 6'h12, 6'h13}, c == 6'h0d, c == 6'h11};
    endfunction : req_of
    function automatic logic jump_of(input logic [5:0] c);
        case (c)
            6'h16: return ac == 8'h00;
            6'h17: return ac != 8'h00;
            6'h18: return cy;
            6'h19: return !cy;
            6'h1a, 6'h1c: return bt;
            6'h1b: return !bt;
            6'h21, 6'h22: return oa != 8'h01;
            6'h14, 6'h15: return 1'b1;
            default: return oa != ob;
        endcase
    endfunction : jump_of
    task automatic run_op(input logic [7:0] op);
        logic [11:0] e;
        logic [2:0] w;
        int k;
        int n;
        bit got;
        w = 3'($urandom);
        e = model(op, w);
        op_valid <= 1'b1;
        op_byte <= op;
        ext_wait <= w;
        ac <= $urandom_range(1) ? 8'h00 : 8'($urandom);
        oa <= $urandom_range(1) ? 8'h01 : 8'($urandom);
        ob <= $urandom_range(1) ? 8'h01 : 8'($urandom);
        {cy, bt} <= 2'($urandom);
        k = 0;
        n = 0;
        got = 1'b0;
        do begin
            @(posedge sys_clk);
            k++;
            // a done pulse frozen by a low enable belongs to the previous opcode
            if (!got && op_ready === 1'b1 && clk_en === 1'b1) begin
                op_valid <= 1'b0;
                got = 1'b1;
            end
            if (busy === 1'b1 && clk_en === 1'b1) begin
                n++;
                check(reqs, req_of(e[11:6]));
            end
            clk_en <= $urandom_range(3) != 0;
        end while (!(got && exec_done === 1'b1) && k < 80);
        if (k >= 80) begin
            n_errors++;
            stop_test();
        end
        check({dec_valid, dec_class, dec_len, dec_cycles}, {1'b1, e});
        check(16'(n), 16'(e[3:0]));
        check({bank_sel, ptr_sel, call_addr_hi, unsupported}, {op[2:0], op[0], op[7:5], e[11:6] == 6'h00});
        if (e[11:6] inside {[6'h14:6'h22]}) check(jump_taken, jump_of(e[11:6]));
        check(bit_clear_req, e[11:6] == 6'h1c && bt);
        check(compare_below, e[11:6] inside {[6'h1d:6'h20]} && oa < ob);
    endtask : run_op
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        n_errors = 0;
        checks = 0;
        {rst_b, op_valid, op_byte, ext_wait, ac, oa, ob, cy, bt} = '0;
        clk_en = 1'b1;
        void'($urandom(32'h23a9));
        repeat (6) @(posedge sys_clk);
        check({dec_valid, busy, exec_done, op_ready, dec_len, dec_cycles}, {4'h0, mbd_pkg::LEN_1, mbd_pkg::CYC_1});
        rst_b <= 1'b1;
        for (int i = 0; i < 256; i++) begin
            run_op(8'(i));
        end
        stop_test();
    end
endmodule : mbd_decoder_top_bench
bind mbd_decoder_top mbd_decoder_properties i_mbd_decoder_properties (.sys_clk, .rst_b, .clk_en, .op_valid,
    .op_ready, .dec_valid, .dec_class, .dec_len, .dec_cycles, .busy, .exec_done);
